// [common/timers_map.svh]
`ifndef TIMERS_MAP_SVH
`define TIMERS_MAP_SVH

// register indices; byte address is four times the index
`define IDX_BASIC_CTRL 8'h88
`define IDX_BASIC_MODE 8'h89
`define IDX_LOW0 8'h8A
`define IDX_LOW1 8'h8B
`define IDX_HIGH0 8'h8C
`define IDX_HIGH1 8'h8D
`define IDX_THIRD_CTRL 8'hC8
`define IDX_THIRD_MODE 8'hC9
`define IDX_THIRD_RELOAD_LO 8'hCA
`define IDX_THIRD_RELOAD_HI 8'hCB
`define IDX_THIRD_LO 8'hCC
`define IDX_THIRD_HI 8'hCD

// basic control register fields
`define B_OVF1 7
`define B_RUN1 6
`define B_OVF0 5
`define B_RUN0 4

// basic mode register fields
`define B_GATE1 7
`define B_SRC1 6
`define B_GATE0 3
`define B_SRC0 2

// basic timer modes
`define MODE_13BIT 2'b00
`define MODE_16BIT 2'b01
`define MODE_RELOAD8 2'b10
`define MODE_SPLIT 2'b11

// third timer control fields
`define C_OVF 7
`define C_EXT 6
`define C_RXSEL 5
`define C_TXSEL 4
`define C_EXTEN 3
`define C_RUN 2
`define C_SRC 1
`define C_CAPSEL 0

// third timer mode fields
`define M_OUTEN 1
`define M_UPDOWN 0

`define RESET_BYTE 8'h00

// oscillator clocks per machine cycle
`define MC_CLKS 6

`endif

// [common/timers_pkg.sv]
package timers_pkg;

typedef enum logic [2:0] {
    T3_OFF,
    T3_RELOAD,
    T3_CAPTURE,
    T3_CLKOUT,
    T3_BAUD
} third_mode_t;

endpackage

// [logic/fall_detect.sv]
`timescale 1ns/10ps
module fall_detect #(
    parameter int W = 4
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [W-1:0] pins,
    output logic [W-1:0] falls
);

logic [W-1:0] prev_r;

// idle-high reset so a pin already low at release counts as a fall in the first clock
always_ff @(posedge hclk or negedge hresetn)
begin
    if (!hresetn)
        prev_r <= '1;
    else
        prev_r <= pins;
end

assign falls = prev_r & ~pins;

endmodule

// [logic/dual_timer.sv]
// Design decision made here: the AHB-Lite register port.
`timescale 1ns/10ps
`include "timers_map.svh"
module dual_timer #(
    parameter int MC_CLKS = `MC_CLKS
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic first_gate_pin,
    input wire logic second_gate_pin,
    input wire logic [2:0] count_pins,
    input wire logic trigger_pin,
    input wire logic [1:0] vector_ack,
    output logic [1:0] basic_overflow_flag,
    output logic third_timer_request,
    output logic rx_baud_tick,
    output logic tx_baud_tick,
    output logic clock_out
);

import timers_pkg::*;

// bus slave: one wait state so a write lands before any later read samples
logic pend_r, wr_r, hreadyout_r;
logic [7:0] idx_r;
logic [31:0] hrdata_r;
wire addr_ok = hsel & htrans[1] & hready;
wire wr_en = pend_r & wr_r;
wire [7:0] wdata = hwdata[7:0];
wire wr_ctrl = wr_en & (idx_r == `IDX_BASIC_CTRL);
wire wr_mode = wr_en & (idx_r == `IDX_BASIC_MODE);
wire wr_low0 = wr_en & (idx_r == `IDX_LOW0);
wire wr_low1 = wr_en & (idx_r == `IDX_LOW1);
wire wr_high0 = wr_en & (idx_r == `IDX_HIGH0);
wire wr_high1 = wr_en & (idx_r == `IDX_HIGH1);
wire wr_c3 = wr_en & (idx_r == `IDX_THIRD_CTRL);
wire wr_m3 = wr_en & (idx_r == `IDX_THIRD_MODE);
wire wr_rl = wr_en & (idx_r == `IDX_THIRD_RELOAD_LO);
wire wr_rh = wr_en & (idx_r == `IDX_THIRD_RELOAD_HI);
wire wr_cl = wr_en & (idx_r == `IDX_THIRD_LO);
wire wr_ch = wr_en & (idx_r == `IDX_THIRD_HI);

logic [7:0] ctrl_r, mode_r, ctrl3_r;
logic [1:0] mode3_r;
logic [7:0] low_r [2];
logic [7:0] high_r [2];
logic [15:0] cnt3_r, cap3_r;
logic [7:0] mc_cnt_r;
logic rx_r, tx_r, clk_out_r, req_r;

wire [7:0] rd_byte =
    (idx_r == `IDX_BASIC_CTRL) ? ctrl_r :
    (idx_r == `IDX_BASIC_MODE) ? mode_r :
    (idx_r == `IDX_LOW0) ? low_r[0] :
    (idx_r == `IDX_LOW1) ? low_r[1] :
    (idx_r == `IDX_HIGH0) ? high_r[0] :
    (idx_r == `IDX_HIGH1) ? high_r[1] :
    (idx_r == `IDX_THIRD_CTRL) ? ctrl3_r :
    (idx_r == `IDX_THIRD_MODE) ? {6'h00, mode3_r} :
    (idx_r == `IDX_THIRD_RELOAD_LO) ? cap3_r[7:0] :
    (idx_r == `IDX_THIRD_RELOAD_HI) ? cap3_r[15:8] :
    (idx_r == `IDX_THIRD_LO) ? cnt3_r[7:0] :
    (idx_r == `IDX_THIRD_HI) ? cnt3_r[15:8] : 8'h00;

always_ff @(posedge hclk or negedge hresetn)
begin
    if (!hresetn)
    begin
        pend_r <= 1'b0;
        wr_r <= 1'b0;
        idx_r <= 8'h00;
        hreadyout_r <= 1'b1;
        hrdata_r <= 32'h00000000;
    end
    else
    begin
        pend_r <= addr_ok;
        hreadyout_r <= ~addr_ok;
        if (addr_ok)
        begin
            idx_r <= haddr[9:2];
            wr_r <= hwrite;
        end
        if (pend_r && !wr_r)
            hrdata_r <= {24'h000000, rd_byte};
    end
end

assign hreadyout = hreadyout_r;
assign hrdata = hrdata_r;
assign hresp = 1'b0;

// machine cycle strobe and pin edges
wire mc_tick = (mc_cnt_r == 8'h00);
wire [3:0] falls;

always_ff @(posedge hclk or negedge hresetn)
begin
    if (!hresetn)
        mc_cnt_r <= 8'h00;
    else
        mc_cnt_r <= (mc_cnt_r == 8'(MC_CLKS - 1)) ? 8'h00 : mc_cnt_r + 8'h01;
end

// pin edges are seen in the clock the pin is first low; falls count on any clock, not once per machine cycle
fall_detect #(.W(4)) edges (
    .hclk(hclk),
    .hresetn(hresetn),
    .pins({trigger_pin, count_pins}),
    .falls(falls)
);

// one counting step of a basic timer: {overflow, high, low}
function automatic logic [16:0] step(input logic [1:0] m, input logic [7:0] lo,
    input logic [7:0] hi, input logic en);
    logic [12:0] v13;
    logic [15:0] v16;
    logic [8:0] v8;
    v13 = {hi, lo[4:0]} + 13'h0001;
    v16 = {hi, lo} + 16'h0001;
    v8 = {1'b0, lo} + 9'h001;
    step = {1'b0, hi, lo};
    if (en)
    begin
        unique case (m)
            `MODE_13BIT: step = {&{hi, lo[4:0]}, v13[12:5], lo[7:5], v13[4:0]};
            `MODE_16BIT: step = {&{hi, lo}, v16};
            `MODE_RELOAD8: step = {v8[8], hi, (v8[8] ? hi : v8[7:0])};
            `MODE_SPLIT: step = {v8[8], hi, v8[7:0]};
        endcase
    end
endfunction

wire [1:0] m0 = mode_r[1:0];
wire [1:0] m1 = mode_r[5:4];
wire split0 = (m0 == `MODE_SPLIT);
wire src0 = mode_r[`B_SRC0] ? falls[0] : mc_tick;
wire src1 = mode_r[`B_SRC1] ? falls[1] : mc_tick;
wire en0 = ctrl_r[`B_RUN0] & (~mode_r[`B_GATE0] | first_gate_pin) & src0;
// while the first timer is split its high byte owns the run bit, so only its own split mode or its gate stops this one
wire run1_eff = ctrl_r[`B_RUN1] | split0;
wire en1 = run1_eff & (m1 != `MODE_SPLIT) & (~mode_r[`B_GATE1] | second_gate_pin) & src1;
wire [16:0] st0 = step(m0, low_r[0], high_r[0], en0);
wire [16:0] st1 = step(m1, low_r[1], high_r[1], en1);
wire ovf0 = st0[16];
wire ovf1 = st1[16];

// split high byte: machine cycles only, run by the second timer's run bit
wire hsplit_en = split0 & ctrl_r[`B_RUN1] & mc_tick;
wire hsplit_ovf = hsplit_en & (&high_r[0]);
wire [7:0] high0_cnt = split0 ? high_r[0] + {7'h00, hsplit_en} : st0[15:8];
wire ovf1_flag = split0 ? hsplit_ovf : ovf1;

// a flag set in the cycle it is cleared stays set
wire [7:0] ctrl_base = wr_ctrl ? wdata : ctrl_r;
wire tf0_n = ovf0 | (ctrl_base[`B_OVF0] & ~vector_ack[0]);
wire tf1_n = ovf1_flag | (ctrl_base[`B_OVF1] & ~vector_ack[1]);
wire [7:0] ctrl_nxt = {tf1_n, ctrl_base[6], tf0_n, ctrl_base[4:0]};

wire [7:0] low_nxt [2];
wire [7:0] high_nxt [2];
assign low_nxt[0] = wr_low0 ? wdata : st0[7:0];
assign low_nxt[1] = wr_low1 ? wdata : st1[7:0];
assign high_nxt[0] = wr_high0 ? wdata : high0_cnt;
assign high_nxt[1] = wr_high1 ? wdata : st1[15:8];

genvar gi;
generate
    for (gi = 0; gi < 2; gi++)
    begin : g_basic
        always_ff @(posedge hclk or negedge hresetn)
        begin
            if (!hresetn)
            begin
                low_r[gi] <= `RESET_BYTE;
                high_r[gi] <= `RESET_BYTE;
            end
            else
            begin
                low_r[gi] <= low_nxt[gi];
                high_r[gi] <= high_nxt[gi];
            end
        end
    end
endgenerate

always_ff @(posedge hclk or negedge hresetn)
begin
    if (!hresetn)
    begin
        ctrl_r <= `RESET_BYTE;
        mode_r <= `RESET_BYTE;
    end
    else
    begin
        ctrl_r <= ctrl_nxt;
        if (wr_mode)
            mode_r <= wdata;
    end
end

assign basic_overflow_flag = {ctrl_r[`B_OVF1], ctrl_r[`B_OVF0]};

// third timer
third_mode_t t3_mode;
wire serial_sel = ctrl3_r[`C_RXSEL] | ctrl3_r[`C_TXSEL];
assign t3_mode = !ctrl3_r[`C_RUN] ? T3_OFF :
    serial_sel ? T3_BAUD :
    ctrl3_r[`C_CAPSEL] ? T3_CAPTURE :
    mode3_r[`M_OUTEN] ? T3_CLKOUT : T3_RELOAD;

// baud and clock-out count every clock unless pin-clocked, as the serial port expects
logic t3_fast;
always_comb
begin
    t3_fast = 1'b0;
    unique case (t3_mode)
        T3_BAUD, T3_CLKOUT: t3_fast = 1'b1;
        T3_OFF, T3_RELOAD, T3_CAPTURE: t3_fast = 1'b0;
    endcase
end

wire t3_tick = ctrl3_r[`C_SRC] ? falls[2] : (t3_fast | mc_tick);
wire t3_run = (t3_mode != T3_OFF);
wire t3_ovf = t3_run & t3_tick & (&cnt3_r);
wire t3_flagged = (t3_mode == T3_RELOAD) | (t3_mode == T3_CAPTURE);
wire trig = falls[3] & ctrl3_r[`C_EXTEN] & (t3_flagged | (t3_mode == T3_BAUD));
wire do_capture = trig & (t3_mode == T3_CAPTURE);
wire do_reload = (t3_ovf & (t3_mode != T3_CAPTURE)) | (trig & (t3_mode == T3_RELOAD));

wire [15:0] cnt3_run = do_reload ? cap3_r : (t3_run & t3_tick) ? cnt3_r + 16'h0001 : cnt3_r;
wire [15:0] cnt3_nxt = {wr_ch ? wdata : cnt3_run[15:8], wr_cl ? wdata : cnt3_run[7:0]};
wire [15:0] cap3_src = do_capture ? cnt3_r : cap3_r;
wire [15:0] cap3_nxt = {wr_rh ? wdata : cap3_src[15:8], wr_rl ? wdata : cap3_src[7:0]};

wire [7:0] ctrl3_base = wr_c3 ? wdata : ctrl3_r;
wire tf2_n = (t3_ovf & t3_flagged) | ctrl3_base[`C_OVF];
wire third_timer_external_flag_n = trig | ctrl3_base[`C_EXT];
wire [7:0] ctrl3_nxt = {tf2_n, third_timer_external_flag_n, ctrl3_base[5:0]};

always_ff @(posedge hclk or negedge hresetn)
begin
    if (!hresetn)
    begin
        ctrl3_r <= `RESET_BYTE;
        mode3_r <= 2'b00;
        cnt3_r <= 16'h0000;
        cap3_r <= 16'h0000;
    end
    else
    begin
        ctrl3_r <= ctrl3_nxt;
        cnt3_r <= cnt3_nxt;
        cap3_r <= cap3_nxt;
        if (wr_m3)
            mode3_r <= wdata[1:0];
    end
end

// serial clocks and clock-out; the second timer feeds the port even while split
always_ff @(posedge hclk or negedge hresetn)
begin
    if (!hresetn)
    begin
        rx_r <= 1'b0;
        tx_r <= 1'b0;
        clk_out_r <= 1'b0;
        req_r <= 1'b0;
    end
    else
    begin
        rx_r <= ctrl3_r[`C_RXSEL] ? t3_ovf : ovf1;
        tx_r <= ctrl3_r[`C_TXSEL] ? t3_ovf : ovf1;
        if (t3_ovf && t3_mode == T3_CLKOUT)
            clk_out_r <= ~clk_out_r;
        req_r <= tf2_n | third_timer_external_flag_n;
    end
end

assign rx_baud_tick = rx_r;
assign tx_baud_tick = tx_r;
assign clock_out = clk_out_r;
assign third_timer_request = req_r;

default clocking @(posedge hclk); endclocking
default disable iff (!hresetn);

sequence s_wrap13;
    en0 && m0 == `MODE_13BIT && (&high_r[0]) && (&low_r[0][4:0]) && !wr_low0 && !wr_high0;
endsequence

sequence s_cleared13;
    ctrl_r[`B_OVF0] && high_r[0] == 8'h00 && low_r[0][4:0] == 5'h00;
endsequence

wrap_thirteen_a: assert property (s_wrap13 |=> s_cleared13)
    else $error("13-bit wrap did not clear count and set flag");

gate_hold_a: assert property ((!ctrl_r[`B_RUN0] || (mode_r[`B_GATE0] && !first_gate_pin)) && !split0
    && !wr_low0 && !wr_high0 |=> $stable(low_r[0]) && $stable(high_r[0]))
    else $error("first timer counted while stopped or gated");

start_keeps_a: assert property (wr_ctrl && wdata[`B_RUN0] && !ctrl_r[`B_RUN0]
    |=> low_r[0] == $past(low_r[0]) && high_r[0] == $past(high_r[0]))
    else $error("starting the timer changed its count");

reload_eight_a: assert property (en0 && m0 == `MODE_RELOAD8 && low_r[0] == 8'hFF && !wr_low0 && !wr_high0
    |=> low_r[0] == high_r[0] && $stable(high_r[0]) && ctrl_r[`B_OVF0])
    else $error("8-bit reload failed");

split_stop_a: assert property (m1 == `MODE_SPLIT && !wr_low1 && !wr_high1
    |=> $stable(low_r[1]) && $stable(high_r[1]))
    else $error("second timer counted in split mode");

split_high_a: assert property (hsplit_ovf && !wr_ctrl && !vector_ack[1]
    |=> ctrl_r[`B_OVF1] ##1 1'b1)
    else $error("split high byte overflow missed its flag");

serial_noflag_a: assert property (serial_sel && !ctrl3_r[`C_OVF] && !wr_c3
    |=> !ctrl3_r[`C_OVF])
    else $error("third overflow flag set while clocking the serial port");

ext_flag_a: assert property (falls[3] && ctrl3_r[`C_EXTEN] && t3_mode == T3_CAPTURE
    |=> ctrl3_r[`C_EXT] && cap3_r == $past(cnt3_r))
    else $error("trigger fall missed capture or external flag");

tx_route_a: assert property (ctrl3_r[`C_TXSEL] && t3_ovf |=> tx_baud_tick)
    else $error("transmit clock not taken from third timer");

rx_route_a: assert property (!ctrl3_r[`C_RXSEL] && ovf1 |=> rx_baud_tick)
    else $error("receive clock not taken from second timer");

ack_clear_a: assert property (vector_ack[0] && !ovf0 && !wr_ctrl |=> !ctrl_r[`B_OVF0])
    else $error("vectoring did not clear first overflow flag");

endmodule

// [tb/pin_model.sv]
`timescale 1ns/10ps
module pin_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [1:0] gate_lvl,
    input wire logic [3:0] fall_req,
    output logic first_gate_pin,
    output logic second_gate_pin,
    output logic [2:0] count_pins,
    output logic trigger_pin
);
    logic [3:0] low_r;
    logic [1:0] cnt_r;
    // a fall is held low several clocks so the sampler never misses it
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            low_r <= 4'h0;
            cnt_r <= 2'h0;
        end
        else if (fall_req != 4'h0)
        begin
            low_r <= fall_req;
            cnt_r <= 2'h3;
        end
        else if (cnt_r != 2'h0)
            cnt_r <= cnt_r - 2'h1;
        else
            low_r <= 4'h0;
    end
    // pins idle high between events
    assign {trigger_pin, count_pins} = ~low_r;
    assign first_gate_pin = gate_lvl[0];
    assign second_gate_pin = gate_lvl[1];
endmodule

// [tb/dual_timer_and_timer2_control_bench.sv]
`timescale 1ns/10ps
`include "timers_map.svh"
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp); end end
module dual_timer_and_timer2_control_bench;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0] gate_lvl = 2'h3;
    logic [3:0] fall_req = 4'h0;
    logic [1:0] vector_ack = 2'h0;
    logic hreadyout, hresp, gate0, gate1, trig, third_timer_request, rx_baud_tick, tx_baud_tick, clock_out;
    logic [31:0] hrdata;
    logic [2:0] count_pins;
    logic [1:0] basic_overflow_flag;
    logic [7:0] exp_q[$];
    logic [7:0] e_now;
    logic [7:0] start;
    logic in_rd = 1'b0;
    logic [31:0] lfsr_r = 32'hE4EB7274;
    int n_mismatch = 0;
    int compares = 0;
    int rx_n = 0;
    int tx_n = 0;
    int rx0;
    int tx0;
    int nf;

    always #2.5 hclk = ~hclk;

    dual_timer #(.MC_CLKS(2)) DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .first_gate_pin(gate0),
        .second_gate_pin(gate1), .count_pins(count_pins), .trigger_pin(trig),
        .vector_ack(vector_ack), .basic_overflow_flag(basic_overflow_flag),
        .third_timer_request(third_timer_request), .rx_baud_tick(rx_baud_tick),
        .tx_baud_tick(tx_baud_tick), .clock_out(clock_out));

    pin_model PINS (.hclk(hclk), .hresetn(hresetn), .gate_lvl(gate_lvl), .fall_req(fall_req),
        .first_gate_pin(gate0), .second_gate_pin(gate1), .count_pins(count_pins), .trigger_pin(trig));

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic bus(input logic [7:0] idx, input logic wr, input logic [7:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {22'h0, idx, 2'b00};
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        bus(idx, 1'b1, d);
    endtask

    task automatic rd(input logic [7:0] idx, input logic [7:0] e);
        exp_q.push_back(e);
        bus(idx, 1'b0, 8'h00);
    endtask

    task automatic pulse_pin(input logic [3:0] p);
        fall_req <= p;
        @(posedge hclk);
        fall_req <= 4'h0;
        repeat (8) @(posedge hclk);
    endtask

    task automatic complete_run;
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // read data is judged where the data phase completes, against the oldest note
    always @(posedge hclk)
    begin
        if (in_rd && hreadyout)
        begin
            e_now = exp_q.pop_front();
            `CHK(hrdata, {24'h0, e_now})
        end
        if (rx_baud_tick === 1'b1)
            rx_n <= rx_n + 1;
        if (tx_baud_tick === 1'b1)
            tx_n <= tx_n + 1;
        in_rd <= (hsel && htrans[1] && !hwrite && hreadyout) || (in_rd && !hreadyout);
    end

    initial
    begin
        #100000;
        n_mismatch++;
        complete_run();
    end

    initial
    begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        rd(`IDX_BASIC_CTRL, 8'h00);
        rd(`IDX_THIRD_CTRL, `RESET_BYTE);
        rd(8'h40, 8'h00);
        wr(`IDX_THIRD_MODE, 8'h03);
        rd(`IDX_THIRD_MODE, 8'h03);
        `CHK(hresp, 1'b0)
        $display("registers done");
        gate_lvl <= 2'h0;
        wr(`IDX_BASIC_MODE, 8'h08);
        wr(`IDX_LOW0, 8'h11);
        wr(`IDX_BASIC_CTRL, 8'h10);
        repeat (12) @(posedge hclk);
        rd(`IDX_LOW0, 8'h11);
        gate_lvl <= 2'h3;
        $display("gate done");
        wr(`IDX_BASIC_CTRL, 8'h00);
        wr(`IDX_BASIC_MODE, 8'h01);
        wr(`IDX_LOW0, 8'hFF);
        wr(`IDX_HIGH0, 8'hFF);
        wr(`IDX_BASIC_CTRL, 8'h10);
        repeat (6) @(posedge hclk);
        `CHK(basic_overflow_flag, 2'b01)
        rd(`IDX_HIGH0, 8'h00);
        vector_ack <= 2'b01;
        @(posedge hclk);
        vector_ack <= 2'b00;
        repeat (2) @(posedge hclk);
        `CHK(basic_overflow_flag, 2'b00)
        wr(`IDX_BASIC_CTRL, 8'h00);
        wr(`IDX_BASIC_MODE, 8'h00);
        wr(`IDX_LOW0, 8'h1F);
        wr(`IDX_HIGH0, 8'hFF);
        wr(`IDX_BASIC_CTRL, 8'h10);
        repeat (6) @(posedge hclk);
        `CHK(basic_overflow_flag, 2'b01)
        rd(`IDX_HIGH0, 8'h00);
        wr(`IDX_BASIC_CTRL, 8'h00);
        wr(`IDX_BASIC_MODE, 8'h02);
        wr(`IDX_HIGH0, 8'hA0);
        wr(`IDX_LOW0, 8'hFF);
        wr(`IDX_BASIC_CTRL, 8'h10);
        repeat (6) @(posedge hclk);
        rd(`IDX_HIGH0, 8'hA0);
        rd(`IDX_BASIC_CTRL, 8'h30);
        $display("modes done");
        wr(`IDX_BASIC_CTRL, 8'h00);
        wr(`IDX_BASIC_MODE, 8'h33);
        wr(`IDX_LOW1, 8'hFF);
        wr(`IDX_HIGH1, 8'hFF);
        wr(`IDX_LOW0, 8'h00);
        wr(`IDX_HIGH0, 8'hFF);
        wr(`IDX_BASIC_CTRL, 8'h40);
        repeat (8) @(posedge hclk);
        rd(`IDX_BASIC_CTRL, 8'hC0);
        rd(`IDX_LOW0, 8'h00);
        rd(`IDX_LOW1, 8'hFF);
        $display("split done");
        wr(`IDX_BASIC_CTRL, 8'h00);
        wr(`IDX_BASIC_MODE, 8'h05);
        lfsr_r = lfsr_next(lfsr_r);
        start = lfsr_r[7:0] & 8'hF0;
        nf = lfsr_r[9:8] + 1;
        wr(`IDX_LOW0, start);
        wr(`IDX_HIGH0, 8'h00);
        wr(`IDX_BASIC_CTRL, 8'h10);
        repeat (nf) pulse_pin(4'h1);
        rd(`IDX_LOW0, start + 8'(nf));
        wr(`IDX_BASIC_CTRL, 8'h00);
        $display("pin count done");
        wr(`IDX_LOW1, 8'hFF);
        wr(`IDX_HIGH1, 8'hFF);
        rx0 = rx_n;
        wr(`IDX_BASIC_MODE, 8'h13);
        repeat (8) @(posedge hclk);
        `CHK(rx_n - rx0, 1)
        rd(`IDX_BASIC_CTRL, 8'h00);
        wr(`IDX_BASIC_MODE, 8'h33);
        $display("split serial done");
        wr(`IDX_THIRD_LO, 8'hFF);
        wr(`IDX_THIRD_HI, 8'hFF);
        rx0 = rx_n;
        tx0 = tx_n;
        wr(`IDX_THIRD_CTRL, 8'h34);
        repeat (12) @(posedge hclk);
        `CHK(rx_n - rx0, 1)
        `CHK(tx_n - tx0, 1)
        rd(`IDX_THIRD_CTRL, 8'h34);
        wr(`IDX_THIRD_CTRL, 8'h00);
        wr(`IDX_THIRD_LO, 8'hFF);
        wr(`IDX_THIRD_HI, 8'hFF);
        wr(`IDX_THIRD_MODE, 8'h02);
        wr(`IDX_THIRD_CTRL, 8'h04);
        repeat (12) @(posedge hclk);
        `CHK(clock_out, 1'b1)
        rd(`IDX_THIRD_CTRL, 8'h04);
        wr(`IDX_THIRD_CTRL, 8'h00);
        wr(`IDX_THIRD_MODE, 8'h00);
        wr(`IDX_THIRD_LO, 8'hFF);
        wr(`IDX_THIRD_HI, 8'hFF);
        wr(`IDX_THIRD_CTRL, 8'h0C);
        repeat (8) @(posedge hclk);
        rd(`IDX_THIRD_CTRL, 8'h8C);
        `CHK(third_timer_request, 1'b1)
        pulse_pin(4'h8);
        rd(`IDX_THIRD_CTRL, 8'hCC);
        wr(`IDX_THIRD_CTRL, 8'h00);
        wr(`IDX_THIRD_LO, 8'h55);
        repeat (8) @(posedge hclk);
        rd(`IDX_THIRD_LO, 8'h55);
        wr(`IDX_THIRD_HI, 8'h12);
        wr(`IDX_THIRD_CTRL, 8'h0F);
        pulse_pin(4'h8);
        rd(`IDX_THIRD_RELOAD_LO, 8'h55);
        rd(`IDX_THIRD_RELOAD_HI, 8'h12);
        rd(`IDX_THIRD_CTRL, 8'h4F);
        $display("third timer done");
        complete_run();
    end
endmodule
